/* pkg/cvs_regs.vh */
// constants for the calibration and validation sequencer
`ifndef CVS_REGS_VH
`define CVS_REGS_VH

// word width of the parameter, command, state and status registers
`define CVS_W           16
`define CVS_CNT_W       8
`define CVS_UC_PER_CH   4

// use-case slots within a channel
`define CVS_UC_VAL_A    2'h0
`define CVS_UC_CAL_A    2'h1
`define CVS_UC_VAL_B    2'h2
`define CVS_UC_CAL_B    2'h3

// handshake register values
`define CVS_PARAM_RST   16'h0000
`define CVS_ACK_READY   1'b1
`define CVS_ACK_TAKEN   1'b0

// commands
`define CVS_CMD_NONE    16'h0000
`define CVS_CMD_START   16'h0001
`define CVS_CMD_RESET   16'h0002
`define CVS_CMD_CANCEL  16'h0003

// main machine states
`define CVS_ST_INIT     16'h0001
`define CVS_ST_FINAL    16'h0002
`define CVS_ST_NOSUP    16'h0008
`define CVS_ST_BUSY     16'h0009
`define CVS_ST_START    16'h000a
`define CVS_ST_ERR_MIN  16'h0384
`define CVS_ST_INVALID  16'h03e7

// channel status codes
`define CVS_STAT_NO_SENSOR   16'h0000
`define CVS_STAT_STERIL_OVF  16'h0001
`define CVS_STAT_PRE_USE     16'h0004
`define CVS_STAT_CAL_INV     16'h0005
`define CVS_STAT_CAL_INV_SN  16'h0006
`define CVS_STAT_SEN_USE     16'h0007
`define CVS_STAT_CAL_RANGE   16'h0008
`define CVS_STAT_CLEANING    16'h0009
`define CVS_STAT_OVERTEMP    16'h000a
`define CVS_STAT_OUT_RANGE   16'h000b
`define CVS_STAT_OK          16'h000c
`define CVS_STAT_SIMULATOR   16'h000d
`define CVS_STAT_AUTO_MAX    16'h000e
`define CVS_STAT_SEN_CAL_AGE 16'h000f
`define CVS_STAT_PRE_CAL_AGE 16'h0010
`define CVS_STAT_NO_PREAMP   16'h0011
`define CVS_STAT_FW_UPDATE   16'h0012

// limits, counts in units, ages in months
`define CVS_STERIL_MAX      8'h64
`define CVS_PRE_USE_MAX_MON 8'h0c
`define CVS_SEN_USE_MAX_MON 8'h06
`define CVS_CAL_AGE_MAX_MON 8'h0c

// condition pin positions within a channel
`define CVS_FLG_SENSOR  0
`define CVS_FLG_PREAMP  1
`define CVS_FLG_FWUPD   2
`define CVS_FLG_SIM     3
`define CVS_FLG_CLEAN   4
`define CVS_FLG_OVTEMP  5
`define CVS_FLG_RANGE   6
`define CVS_FLG_CALINV  7
`define CVS_FLG_SNINV   8
`define CVS_FLG_CALRNG  9
`define CVS_FLG_N       10

// edges after reset release before the strap is trusted
`define CVS_BOOT_CYC    2'h2

`endif

/* rtl/cvs_sync.v */
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module cvs_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

/* rtl/cvs_status_enc.v */
// channel status code encoder, highest severity first
`timescale 1ns/1ps
`include "cvs_regs.vh"
module cvs_status_enc (
  // synchronised condition levels
  input  wire [`CVS_FLG_N-1:0] flags,
  // counters and ages
  input  wire [`CVS_CNT_W-1:0] steril_cnt,
  input  wire [`CVS_CNT_W-1:0] auto_cnt,
  input  wire [`CVS_CNT_W-1:0] pre_use,
  input  wire [`CVS_CNT_W-1:0] sen_use,
  input  wire [`CVS_CNT_W-1:0] sen_cal_age,
  input  wire [`CVS_CNT_W-1:0] pre_cal_age,
  // code
  output reg  [`CVS_W-1:0]     code
);

  // a missing preamp hides everything behind it, so it is checked first
  always @* begin
    if (!flags[`CVS_FLG_PREAMP])
      code = `CVS_STAT_NO_PREAMP;
    else if (flags[`CVS_FLG_FWUPD])
      code = `CVS_STAT_FW_UPDATE;
    else if (flags[`CVS_FLG_SIM])
      code = `CVS_STAT_SIMULATOR;
    else if (!flags[`CVS_FLG_SENSOR])
      code = `CVS_STAT_NO_SENSOR;
    else if (flags[`CVS_FLG_OVTEMP])
      code = `CVS_STAT_OVERTEMP;
    else if (flags[`CVS_FLG_CLEAN])
      code = `CVS_STAT_CLEANING;
    else if (flags[`CVS_FLG_RANGE])
      code = `CVS_STAT_OUT_RANGE;
    else if (steril_cnt > `CVS_STERIL_MAX)
      code = `CVS_STAT_STERIL_OVF;
    else if (auto_cnt >= `CVS_STERIL_MAX)
      code = `CVS_STAT_AUTO_MAX;
    else if (flags[`CVS_FLG_CALINV] && flags[`CVS_FLG_SNINV])
      code = `CVS_STAT_CAL_INV_SN;
    else if (flags[`CVS_FLG_CALINV])
      code = `CVS_STAT_CAL_INV;
    else if (flags[`CVS_FLG_CALRNG])
      code = `CVS_STAT_CAL_RANGE;
    else if (pre_use > `CVS_PRE_USE_MAX_MON)
      code = `CVS_STAT_PRE_USE;
    else if (sen_use > `CVS_SEN_USE_MAX_MON)
      code = `CVS_STAT_SEN_USE;
    else if (pre_cal_age > `CVS_CAL_AGE_MAX_MON)
      code = `CVS_STAT_PRE_CAL_AGE;
    else if (sen_cal_age > `CVS_CAL_AGE_MAX_MON)
      code = `CVS_STAT_SEN_CAL_AGE;
    else
      code = `CVS_STAT_OK;
  end

endmodule

/* rtl/cvs_seq.v */
// calibration and validation sequencer with channel status reporting
`timescale 1ns/1ps
`include "cvs_regs.vh"
module cvs_seq #(
  parameter N_CH = 2
) (
  // clock and reset
  input  wire                          REF_CLK,
  input  wire                          RST_N,
  // start-up strap
  input  wire                          KIT_MODE_PIN,
  // master writes, one strobe per use case
  input  wire [N_CH*4-1:0]             PARAM_WE,
  input  wire [`CVS_W-1:0]             PARAM_WDATA,
  input  wire [N_CH*4-1:0]             CMD_WE,
  input  wire [`CVS_W-1:0]             CMD_WDATA,
  // use-case register read-back
  output wire [N_CH*4*`CVS_W-1:0]      PARAM_Q,
  output wire [N_CH*4*`CVS_W-1:0]      CMD_Q,
  output wire [N_CH*4-1:0]             ACK_Q,
  output wire [N_CH*4*`CVS_W-1:0]      STATE_Q,
  // channel condition pins
  input  wire [N_CH*`CVS_FLG_N-1:0]    COND_PINS,
  // channel counters and ages
  input  wire [N_CH*`CVS_CNT_W-1:0]    STERIL_CNT,
  input  wire [N_CH*`CVS_CNT_W-1:0]    AUTO_STERIL_CNT,
  input  wire [N_CH*`CVS_CNT_W-1:0]    PREAMP_USE_MON,
  input  wire [N_CH*`CVS_CNT_W-1:0]    SENSOR_USE_MON,
  input  wire [N_CH*`CVS_CNT_W-1:0]    SENSOR_CAL_MON,
  input  wire [N_CH*`CVS_CNT_W-1:0]    PREAMP_CAL_MON,
  // channel status
  output wire [N_CH*`CVS_W-1:0]        STATUS_Q,
  // sub-sequence engine
  output reg                           SUB_START,
  output reg                           SUB_CMD_STB,
  output reg  [`CVS_W-1:0]             SUB_CMD,
  output reg  [`CVS_W-1:0]             SUB_PARAM,
  output reg  [$clog2(N_CH*4)-1:0]     SUB_UC,
  input  wire                          SUB_DONE,
  input  wire [`CVS_W-1:0]             SUB_STATE,
  // global state
  output reg                           KIT_MODE_Q,
  output reg                           BUSY_Q,
  output reg  [$clog2(N_CH*4)-1:0]     OWNER_UC
);

  localparam integer N_UC = N_CH * `CVS_UC_PER_CH;
  localparam integer UCW  = $clog2(N_UC);
  localparam integer SW   = `CVS_W;
  localparam integer NF   = `CVS_FLG_N;
  localparam integer CW   = `CVS_CNT_W;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  wire [N_CH*NF:0] pin_sync;
  wire             kit_pin_s;

  cvs_sync #(
    .W (N_CH*NF+1)
  ) u_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({KIT_MODE_PIN, COND_PINS}),
    .q     (pin_sync)
  );

  assign kit_pin_s = pin_sync[N_CH*NF];

  // ---------------------------------------------------------------
  // start-up: strap is trusted only once the synchroniser is full
  // ---------------------------------------------------------------
  reg  [1:0] boot_cnt_reg;
  reg        boot_done_reg;
  wire       boot_fire;

  assign boot_fire = ~boot_done_reg & (boot_cnt_reg == `CVS_BOOT_CYC);

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_cnt_reg  <= 2'h0;
      boot_done_reg <= 1'b0;
      KIT_MODE_Q    <= 1'b0;
    end else if (!boot_done_reg) begin
      if (boot_fire) begin
        boot_done_reg <= 1'b1;
        KIT_MODE_Q    <= kit_pin_s;
      end else begin
        boot_cnt_reg <= boot_cnt_reg + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // cross-use-case signals
  // ---------------------------------------------------------------
  wire [N_UC-1:0]    start_req;
  wire [N_UC-1:0]    rel_req;
  wire [N_UC-1:0]    sub_go;
  wire [N_UC*SW-1:0] cmd_all;
  wire [N_UC*SW-1:0] param_all;
  reg  [N_UC-1:0]    grant;
  reg  [UCW-1:0]     grant_idx;
  integer            k;

  // lowest index wins when two starts land in the same cycle
  always @* begin
    grant     = {N_UC{1'b0}};
    grant_idx = {UCW{1'b0}};
    if (!BUSY_Q) begin
      for (k = N_UC-1; k >= 0; k = k - 1) begin
        if (start_req[k]) begin
          grant     = {{(N_UC-1){1'b0}}, 1'b1} << k;
          grant_idx = k[UCW-1:0];
        end
      end
    end
  end

  // single owner across all channels
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUSY_Q   <= 1'b0;
      OWNER_UC <= {UCW{1'b0}};
    end else if (|rel_req) begin
      BUSY_Q <= 1'b0;
    end else if (|grant) begin
      BUSY_Q   <= 1'b1;
      OWNER_UC <= grant_idx;
    end
  end

  // hand-off to the sub-sequence engine; only the owner can reach it
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SUB_START   <= 1'b0;
      SUB_CMD_STB <= 1'b0;
      SUB_CMD     <= `CVS_CMD_NONE;
      SUB_PARAM   <= `CVS_PARAM_RST;
      SUB_UC      <= {UCW{1'b0}};
    end else begin
      SUB_START   <= |grant;
      SUB_CMD_STB <= |sub_go;
      if (|grant) begin
        SUB_CMD   <= `CVS_CMD_START;
        SUB_PARAM <= param_all[grant_idx*SW +: SW];
        SUB_UC    <= grant_idx;
      end else if (|sub_go) begin
        SUB_CMD   <= cmd_all[OWNER_UC*SW +: SW];
        SUB_PARAM <= param_all[OWNER_UC*SW +: SW];
        SUB_UC    <= OWNER_UC;
      end
    end
  end

  // ---------------------------------------------------------------
  // one independent machine per use case
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_UC; gi = gi + 1) begin : g_uc
      localparam [UCW-1:0] MY = gi;
      reg  [SW-1:0] param_reg;
      reg  [SW-1:0] cmd_reg;
      reg  [SW-1:0] state_reg;
      reg           ack_reg;
      reg           pend_reg;
      reg           run_reg;
      reg  [SW-1:0] exec_next;
      wire          wr_cmd;
      wire          cmd_zero;
      wire          take;
      wire          go;
      wire          owned;
      wire          is_err;
      wire          is_sub;
      wire          done;

      assign wr_cmd   = CMD_WE[gi] & boot_done_reg;
      assign cmd_zero = (CMD_WDATA == `CVS_CMD_NONE);
      // a pending or running machine drops new codes without a trace
      assign take     = wr_cmd & ~cmd_zero & ack_reg & ~pend_reg;
      assign go       = wr_cmd & cmd_zero & pend_reg;
      assign owned    = BUSY_Q & (OWNER_UC == MY);
      assign is_err   = (state_reg >= `CVS_ST_ERR_MIN);
      assign is_sub   = (state_reg >= `CVS_ST_START) & ~is_err;
      assign done     = run_reg & SUB_DONE & owned;

      // present state and stored command pick the action; the slot reaches the engine on SUB_UC
      assign start_req[gi] = go & (state_reg == `CVS_ST_INIT) &
                             (cmd_reg == `CVS_CMD_START);
      assign sub_go[gi]    = go & is_sub;
      assign rel_req[gi]   = owned &
                             ((go & (state_reg == `CVS_ST_FINAL) &
                               (cmd_reg == `CVS_CMD_RESET)) |
                              (done & (SUB_STATE == `CVS_ST_INIT)));
      assign cmd_all[gi*SW +: SW]   = cmd_reg;
      assign param_all[gi*SW +: SW] = param_reg;

      // outcome of the pending command in the present state
      always @* begin
        exec_next = state_reg;
        case (state_reg)
          `CVS_ST_NOSUP, `CVS_ST_BUSY: begin
            exec_next = state_reg;
          end
          `CVS_ST_INIT: begin
            if (cmd_reg != `CVS_CMD_START)
              exec_next = `CVS_ST_INVALID;
            else if (grant[gi])
              exec_next = `CVS_ST_START;
          end
          `CVS_ST_FINAL: begin
            if (cmd_reg == `CVS_CMD_RESET)
              exec_next = `CVS_ST_INIT;
            else
              exec_next = `CVS_ST_INVALID;
          end
          default: begin
            if (is_err) begin
              if (cmd_reg == `CVS_CMD_CANCEL)
                exec_next = `CVS_ST_FINAL;
              else
                exec_next = `CVS_ST_INVALID;
            end
          end
        endcase
      end

      always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          param_reg <= `CVS_PARAM_RST;
          cmd_reg   <= `CVS_CMD_NONE;
          ack_reg   <= `CVS_ACK_READY;
          state_reg <= `CVS_ST_INIT;
          pend_reg  <= 1'b0;
          run_reg   <= 1'b0;
        end else begin
          // parameter frozen while the engine works on it
          if (PARAM_WE[gi] && boot_done_reg && !run_reg)
            param_reg <= PARAM_WDATA;
          if (take || (wr_cmd && cmd_zero))
            cmd_reg <= CMD_WDATA;
          if (take) begin
            ack_reg  <= `CVS_ACK_TAKEN;
            pend_reg <= 1'b1;
          end
          if (boot_fire && !kit_pin_s) begin
            state_reg <= `CVS_ST_NOSUP;
          end else if (go) begin
            pend_reg  <= 1'b0;
            state_reg <= exec_next;
            if (is_sub)
              run_reg <= 1'b1;
            else
              ack_reg <= `CVS_ACK_READY;
          end else if (done) begin
            // state takes whatever code the engine reports on completion
            state_reg <= SUB_STATE;
            run_reg   <= 1'b0;
            ack_reg   <= `CVS_ACK_READY;
          end else if (state_reg == `CVS_ST_INIT && BUSY_Q && !owned) begin
            state_reg <= `CVS_ST_BUSY;
          end else if (state_reg == `CVS_ST_BUSY && !BUSY_Q) begin
            state_reg <= `CVS_ST_INIT;
          end
        end
      end

      assign PARAM_Q[gi*SW +: SW] = param_reg;
      assign CMD_Q[gi*SW +: SW]   = cmd_reg;
      assign ACK_Q[gi]            = ack_reg;
      assign STATE_Q[gi*SW +: SW] = state_reg;
    end
  endgenerate

  // ---------------------------------------------------------------
  // channel status, one encoder per channel
  // ---------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc = gc + 1) begin : g_ch
      wire [SW-1:0] code;
      reg  [SW-1:0] status_reg;

      cvs_status_enc u_enc (
        .flags       (pin_sync[gc*NF +: NF]),
        .steril_cnt  (STERIL_CNT[gc*CW +: CW]),
        .auto_cnt    (AUTO_STERIL_CNT[gc*CW +: CW]),
        .pre_use     (PREAMP_USE_MON[gc*CW +: CW]),
        .sen_use     (SENSOR_USE_MON[gc*CW +: CW]),
        .sen_cal_age (SENSOR_CAL_MON[gc*CW +: CW]),
        .pre_cal_age (PREAMP_CAL_MON[gc*CW +: CW]),
        .code        (code)
      );

      // registered so the reported word never glitches mid-read
      always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
          status_reg <= `CVS_STAT_NO_SENSOR;
        else
          status_reg <= code;
      end

      assign STATUS_Q[gc*SW +: SW] = status_reg;
    end
  endgenerate

endmodule

/* verif/cvs_seq_checker.sv */
// concurrent checks on the sequencer ports, focused on use cases 0 and 1
`timescale 1ns/1ps
`include "cvs_regs.vh"
module cvs_seq_checker #(
  parameter N_CH = 2
) (
  input wire                       REF_CLK,
  input wire                       RST_N,
  input wire [N_CH*4-1:0]          CMD_WE,
  input wire [`CVS_W-1:0]          CMD_WDATA,
  input wire [N_CH*4*`CVS_W-1:0]   CMD_Q,
  input wire [N_CH*4-1:0]          ACK_Q,
  input wire [N_CH*4*`CVS_W-1:0]   STATE_Q,
  input wire [N_CH*`CVS_FLG_N-1:0] COND_PINS,
  input wire [N_CH*`CVS_W-1:0]     STATUS_Q,
  input wire                       SUB_START,
  input wire                       SUB_DONE,
  input wire [`CVS_W-1:0]          SUB_STATE,
  input wire                       KIT_MODE_Q,
  input wire                       BUSY_Q,
  input wire [$clog2(N_CH*4)-1:0]  OWNER_UC
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // writes before the fourth edge after release are ignored by design
  reg  [1:0]  boot_reg;
  wire        rdy = boot_reg == 2'h3;
  wire [15:0] s0  = STATE_Q[15:0];
  wire [15:0] s1  = STATE_Q[31:16];
  wire [15:0] c0  = CMD_Q[15:0];
  wire        a0  = ACK_Q[0];
  wire        clr = CMD_WE[0] && CMD_WDATA == 16'h0 && rdy && !a0;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) boot_reg <= 2'h0;
    else if (!rdy) boot_reg <= boot_reg + 2'h1;
  end
  property p_take;
    CMD_WE[0] && CMD_WDATA != 16'h0 && a0 && rdy && KIT_MODE_Q && s0 != 16'h9
      |=> !a0 && c0 == $past(CMD_WDATA);
  endproperty
  property p_refuse;
    !a0 && CMD_WE[0] && CMD_WDATA != 16'h0 |=> c0 == $past(c0);
  endproperty
  property p_start;
    s0 == 16'h1 && c0 == 16'h1 && clr && !BUSY_Q
      |=> s0 == 16'ha && a0 && SUB_START && BUSY_Q && OWNER_UC == 0;
  endproperty
  property p_busy;
    $rose(BUSY_Q) && OWNER_UC == 0 && s1 == 16'h1 && ACK_Q[1] |=> s1 == 16'h9;
  endproperty
  property p_free;
    $fell(BUSY_Q) && s1 == 16'h9 |=> s1 == 16'h1;
  endproperty
  property p_done;
    !a0 && c0 == 16'h0 && s0 >= 16'ha && s0 < 16'h384 && SUB_DONE && BUSY_Q && OWNER_UC == 0
      |=> a0 && s0 == $past(SUB_STATE);
  endproperty
  property p_home;
    s0 == 16'h2 && c0 == 16'h2 && clr |=> s0 == 16'h1 && a0;
  endproperty
  property p_inval;
    s0 == 16'h1 && c0 != 16'h0 && c0 != 16'h1 && clr |=> s0 == 16'h3e7 && a0;
  endproperty
  property p_cancel;
    s0 >= 16'h384 && c0 == 16'h3 && clr |=> s0 == 16'h2 && a0;
  endproperty
  property p_kit_off;
    rdy && !KIT_MODE_Q |-> s0 == 16'h8 && s1 == 16'h8;
  endproperty
  property p_no_amp;
    !COND_PINS[1] [*4] |-> STATUS_Q[15:0] == 16'h11;
  endproperty
  a_take: assert property (p_take) else $error("command not taken");
  a_refuse: assert property (p_refuse) else $error("command overwritten");
  a_start: assert property (p_start) else $error("start failed");
  a_busy: assert property (p_busy) else $error("other not busy");
  a_free: assert property (p_free) else $error("other not freed");
  a_done: assert property (p_done) else $error("engine result lost");
  a_home: assert property (p_home) else $error("final not reset");
  a_inval: assert property (p_inval) else $error("invalid not flagged");
  a_cancel: assert property (p_cancel) else $error("cancel failed");
  a_kit_off: assert property (p_kit_off) else $error("not unsupported");
  a_no_amp: assert property (p_no_amp) else $error("preamp code wrong");
  c_start: cover property (SUB_START);
  c_done: cover property (SUB_DONE && !a0);
  c_cancel: cover property (s0 >= 16'h384 && clr);
endmodule
bind cvs_seq cvs_seq_checker #(.N_CH(N_CH)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_WE(CMD_WE), .CMD_WDATA(CMD_WDATA),
  .CMD_Q(CMD_Q), .ACK_Q(ACK_Q), .STATE_Q(STATE_Q), .COND_PINS(COND_PINS),
  .STATUS_Q(STATUS_Q), .SUB_START(SUB_START), .SUB_DONE(SUB_DONE),
  .SUB_STATE(SUB_STATE), .KIT_MODE_Q(KIT_MODE_Q), .BUSY_Q(BUSY_Q), .OWNER_UC(OWNER_UC)
);

/* verif/cvs_eng_model.sv */
// sub-sequence engine model: answers each strobe once with the forwarded parameter as state
`timescale 1ns/1ps
module cvs_eng_model (
  input wire        clk,
  input wire        rst_n,
  input wire        stb,
  input wire [15:0] param,
  input wire        slow,
  output reg        done,
  output reg [15:0] state
);
  reg [3:0]  cnt;
  reg [15:0] hold;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      done <= 1'b0;
      state <= 16'h0;
      hold <= 16'h0;
    end else begin
      done <= 1'b0;
      // state means nothing between answers, so keep it moving
      state <= ~state;
      if (stb) begin
        hold <= param;
        cnt <= slow ? 4'h6 : 4'h1;
      end else if (cnt == 4'h1) begin
        done <= 1'b1;
        state <= hold;
        cnt <= 4'h0;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

/* verif/testbench.sv */
// self-checking bench for the sequencer
`timescale 1ns/1ps
`include "cvs_regs.vh"
module testbench;
  reg          clk, rst_n, kit, slow;
  reg  [7:0]   pwe, cwe;
  reg  [15:0]  pwd, cwd;
  reg  [19:0]  pins;
  reg  [15:0]  ster, aut, puse, suse, scal, pcal;
  wire [127:0] pq, cq, sq;
  wire [7:0]   aq;
  wire [31:0]  stat;
  wire         sstart, sstb, done, kq, bq;
  wire [15:0]  scmd, spar, sst;
  wire [2:0]   suc, own;
  integer      err_total, checks_done, seed, i, n, cyc;
  reg  [31:0]  r, t;
  reg  [15:0]  ex;
  cvs_seq #(.N_CH(2)) u_dut (
    .REF_CLK(clk), .RST_N(rst_n), .KIT_MODE_PIN(kit), .PARAM_WE(pwe), .PARAM_WDATA(pwd),
    .CMD_WE(cwe), .CMD_WDATA(cwd), .PARAM_Q(pq), .CMD_Q(cq), .ACK_Q(aq), .STATE_Q(sq),
    .COND_PINS(pins), .STERIL_CNT(ster), .AUTO_STERIL_CNT(aut), .PREAMP_USE_MON(puse),
    .SENSOR_USE_MON(suse), .SENSOR_CAL_MON(scal), .PREAMP_CAL_MON(pcal), .STATUS_Q(stat),
    .SUB_START(sstart), .SUB_CMD_STB(sstb), .SUB_CMD(scmd), .SUB_PARAM(spar), .SUB_UC(suc),
    .SUB_DONE(done), .SUB_STATE(sst), .KIT_MODE_Q(kq), .BUSY_Q(bq), .OWNER_UC(own)
  );
  cvs_eng_model u_eng (
    .clk(clk), .rst_n(rst_n), .stb(sstb), .param(spar), .slow(slow), .done(done), .state(sst)
  );
  task give_verdict;
    begin
      if (err_total == 0 && checks_done > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // one write strobe, c selects command or parameter
  task wr(input c, input [2:0] u, input [15:0] d);
    begin
      @(posedge clk);
      if (c) begin
        cwe <= 8'h1 << u;
        cwd <= d;
      end else begin
        pwe <= 8'h1 << u;
        pwd <= d;
      end
      @(posedge clk);
      cwe <= 8'h0;
      pwe <= 8'h0;
      #1;
    end
  endtask
  task op(input [2:0] u, input [15:0] p, input [15:0] c);
    begin
      wr(0, u, p);
      wr(1, u, c);
      wr(1, u, 16'h0);
      repeat (20) if (aq[u] !== 1'b1) begin
        @(posedge clk);
        #1;
      end
    end
  endtask
  task st_all(input [15:0] e, input [3:0] skip);
    for (i = 0; i < 8; i = i + 1) if (i != skip) chk("state", sq[i*16+:16], e);
  endtask
  task do_reset(input k);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      kit <= k;
      repeat (10) @(posedge clk);
      #1;
      for (i = 0; i < 8; i = i + 1) begin
        chk("param", pq[i*16+:16], 16'h0);
        chk("ack", {15'h0, aq[i]}, 16'h1);
      end
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask
  function [7:0] cnt(input [7:0] base, input [1:0] b);
    cnt = b[1] ? base + {7'h0, b[0]} : 8'h0;
  endfunction
  function [15:0] exp_st(input [9:0] f, input [7:0] st, au, pu, su, sc, pc);
    if (!f[1]) exp_st = 16'h11;
    else if (f[2]) exp_st = 16'h12;
    else if (f[3]) exp_st = 16'hd;
    else if (!f[0]) exp_st = 16'h0;
    else if (f[5]) exp_st = 16'ha;
    else if (f[4]) exp_st = 16'h9;
    else if (f[6]) exp_st = 16'hb;
    else if (st > 8'h64) exp_st = 16'h1;
    else if (au >= 8'h64) exp_st = 16'he;
    else if (f[7]) exp_st = f[8] ? 16'h6 : 16'h5;
    else if (f[9]) exp_st = 16'h8;
    else if (pu > 8'h0c) exp_st = 16'h4;
    else if (su > 8'h06) exp_st = 16'h7;
    else if (pc > 8'h0c) exp_st = 16'h10;
    else if (sc > 8'h0c) exp_st = 16'hf;
    else exp_st = 16'hc;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  initial begin
    {rst_n, kit, slow, pwe, cwe, pwd, cwd} = 0;
    {pins, ster, aut, puse, suse, scal, pcal} = 0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    seed = 85767;
    do_reset(1'b0);
    st_all(16'h8, 4'h8);
    chk("kit", {15'h0, kq}, 16'h0);
    op(0, 16'h0, 16'h1);
    chk("state", sq[15:0], 16'h8);
    do_reset(1'b1);
    st_all(16'h1, 4'h8);
    chk("kit", {15'h0, kq}, 16'h1);
    for (n = 0; n < 60; n = n + 1) begin
      r = $random(seed);
      t = $random(seed) & $random(seed) & $random(seed);
      @(posedge clk);
      pins <= (n % 5 == 0) ? t[19:0] : t[19:0] | 20'h00c03;
      ster <= {cnt(8'h64, r[1:0]), cnt(8'h64, r[3:2])};
      aut <= {cnt(8'h63, r[5:4]), cnt(8'h63, r[7:6])};
      puse <= {cnt(8'h0c, r[9:8]), cnt(8'h0c, r[11:10])};
      suse <= {cnt(8'h06, r[13:12]), cnt(8'h06, r[15:14])};
      scal <= {cnt(8'h0c, r[17:16]), cnt(8'h0c, r[19:18])};
      pcal <= {cnt(8'h0c, r[21:20]), cnt(8'h0c, r[23:22])};
      repeat (4) @(posedge clk);
      #1;
      for (i = 0; i < 2; i = i + 1) begin
        ex = exp_st(pins[i*10+:10], ster[i*8+:8], aut[i*8+:8], puse[i*8+:8], suse[i*8+:8],
          scal[i*8+:8], pcal[i*8+:8]);
        chk("sts", stat[i*16+:16], ex);
      end
    end
    wr(0, 0, 16'h3e5);
    chk("param", pq[15:0], 16'h3e5);
    wr(1, 0, 16'h1);
    chk("ack", {15'h0, aq[0]}, 16'h0);
    wr(1, 0, 16'h5);
    chk("cmd", cq[15:0], 16'h1);
    wr(1, 0, 16'h0);
    chk("state", sq[15:0], 16'ha);
    @(posedge clk);
    #1;
    st_all(16'h9, 3'h0);
    op(0, 16'h3e5, 16'h4);
    chk("state", sq[15:0], 16'h3e5);
    chk("subcmd", scmd, 16'h4);
    chk("subuc", {13'h0, suc}, 16'h0);
    op(0, 16'h0, 16'h3);
    chk("state", sq[15:0], 16'h2);
    op(0, 16'h0, 16'h5);
    chk("state", sq[15:0], 16'h3e7);
    op(0, 16'h0, 16'h3);
    op(1, 16'h0, 16'h1);
    chk("state", sq[15:0], 16'h2);
    chk("state", sq[31:16], 16'h9);
    op(0, 16'h0, 16'h2);
    chk("busy", {15'h0, bq}, 16'h0);
    @(posedge clk);
    #1;
    st_all(16'h1, 4'h8);
    op(5, 16'h0, 16'h1);
    chk("owner", {13'h0, own}, 16'h5);
    slow = 1'b1;
    op(5, 16'h1, 16'h4);
    chk("state", sq[95:80], 16'h1);
    @(posedge clk);
    #1;
    chk("subuc", {13'h0, suc}, 16'h5);
    st_all(16'h1, 4'h8);
    op(4, 16'h0, 16'h7);
    chk("state", sq[79:64], 16'h3e7);
    chk("state", sq[95:80], 16'h1);
    op(0, 16'h0, 16'h6);
    chk("state", sq[15:0], 16'h3e7);
    give_verdict;
  end
endmodule
